//--- irq_ctrl_pkg.sv
// constants, types and register map of the four level interrupt controller
// assumes a classic wishbone slave with byte-wide registers in the low data bits
// Operation
// - six sources, each with own vector
// - per-source enable bit allows or blocks
// - global enable blocks all when cleared; the code gates only vector_o with it, irq_o still follows unmasked status
// - level is high bit then low bit
// - only higher level preempts running handler
// - level three handler never preempted
// - higher level wins among simultaneous requests
// - fixed polling order breaks level ties
// - enable register bit layout
// - low priority register bit layout
// - high priority register bit layout
// - reserved bits undefined, software writes zero
package irq_ctrl_pkg;
  localparam int unsigned NUM_SRC = 6;
  localparam int unsigned ADDR_W = 8;
  // register byte addresses
  localparam logic [7:0] ADDR_ENABLE = 8'hA8;
  localparam logic [7:0] ADDR_PRIO_HI = 8'hB7;
  localparam logic [7:0] ADDR_PRIO_LO = 8'hB8;
  localparam logic [7:0] ADDR_STATUS = 8'hC0;
  localparam logic [7:0] ADDR_MASK = 8'hC4;
  localparam logic [7:0] ADDR_SERVICE = 8'hC8;
  // field positions
  localparam int unsigned BIT_GLOBAL_EN = 7;
  localparam logic [7:0] SRC_FIELD_MASK = 8'h3F;
  // reset values; reserved bits are stored as zero
  localparam logic [7:0] RST_ENABLE = 8'h00;
  localparam logic [7:0] RST_PRIO = 8'h00;
  localparam logic [5:0] RST_STATUS = 6'h00;
  localparam logic [5:0] RST_MASK = 6'h00;
  // source index also serves as polling rank, 0 polled first
  typedef enum logic [2:0] {
    SRC_EXT0 = 3'h0,
    SRC_TIMER0 = 3'h1,
    SRC_EXT1 = 3'h2,
    SRC_TIMER1 = 3'h3,
    SRC_SERIAL = 3'h4,
    SRC_TIMER2 = 3'h5
  } src_t;
  // vector presented to the core
  typedef struct packed {
    logic valid;
    logic [2:0] source;
    logic [1:0] level;
  } vector_t;
endpackage : irq_ctrl_pkg

//--- four_level_interrupt_control.sv
// four level priority interrupt controller with wishbone register access
// assumes sources give one-cycle pulses or levels on clk_i, core acks and returns
module four_level_interrupt_control (
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone classic slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [irq_ctrl_pkg::ADDR_W-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // request sources, same clock
  input wire logic [irq_ctrl_pkg::NUM_SRC-1:0] src_req_i,
  // core side
  output irq_ctrl_pkg::vector_t vector_o,
  input wire logic vector_ack_i,
  input wire logic handler_return_i,
  output logic irq_o
);
  import irq_ctrl_pkg::*;

  // reserved bit six of the enable register is never stored
  // software must write zero there, so a stored one would only hide misuse
  localparam logic [7:0] ENABLE_USED = 8'hBF;

  // configuration registers
  logic [7:0] enable_ff; // global enable in bit 7, sources in bits 5:0
  logic [7:0] nxt_enable; // next enable image
  logic [7:0] prio_hi_ff; // upper level bit of each source
  logic [7:0] nxt_prio_hi; // next upper level bits
  logic [7:0] prio_lo_ff; // lower level bit of each source
  logic [7:0] nxt_prio_lo; // next lower level bits
  // event reporting
  logic [5:0] status_ff; // sticky event bits, write one to clear
  logic [5:0] nxt_status; // next event bits
  logic [5:0] mask_ff; // events allowed onto irq_o
  logic [5:0] nxt_mask; // next mask
  // service tracking
  logic [5:0] pend_ff; // requests still waiting for the core
  logic [5:0] nxt_pend; // next pending set
  logic [3:0] active_ff; // one bit per level in service
  logic [3:0] nxt_active; // next in-service set
  vector_t vec_ff; // vector offered to the core
  vector_t nxt_vec; // next vector
  // bus answer
  logic ack_ff; // one-cycle answer
  logic nxt_ack; // next answer
  logic [31:0] rdat_ff; // read data, stands with the answer
  logic [31:0] nxt_rdat; // next read data

  // decoded strobes and arbitration results
  logic bus_req; // request not yet answered
  logic wr_stb; // write strobe on the low byte lane
  logic rd_stb; // read strobe
  logic take; // core accepts the offered vector
  logic ret_lvl; // handler return with a level in service
  logic [5:0] eligible; // pending, enabled and globally allowed
  vector_t winner; // best eligible request
  logic [2:0] cur_top; // highest level in service, bit 2 says valid

  // level of one source: high bit above low bit
  // index is an int so the arbitration loop can pass its counter directly
  function automatic logic [1:0] src_level(input int unsigned i,
                                           input logic [7:0] hi,
                                           input logic [7:0] lo);
    return {hi[i], lo[i]};
  endfunction : src_level

  // highest level in service; bit 2 says whether any level is in service
  // scanned upwards so the last hit is the top
  function automatic logic [2:0] top_active(input logic [3:0] act);
    logic [2:0] r; // running result
    r = 3'h0;
    for (int l = 0; l < 4; l++) begin
      if (act[l]) begin
        r = {1'b1, 2'(l)};
      end
    end
    return r;
  endfunction : top_active

  // a request counts once; ack_ff blocks the cycle in which the answer stands
  assign bus_req = cyc_i && stb_i && !ack_ff;
  // only the low byte lane carries register data
  assign wr_stb = bus_req && we_i && sel_i[0];
  // reads have no side effect, so no lane check is needed
  assign rd_stb = bus_req && !we_i;
  // core takes the vector only while it is valid
  assign take = vector_ack_i && vec_ff.valid;
  // a return with nothing in service is ignored
  assign ret_lvl = handler_return_i && cur_top[2];

  // gating: a source needs its own enable and the global enable
  always_comb begin
    eligible = '0; // nothing allowed by default
    if (enable_ff[BIT_GLOBAL_EN]) begin
      for (int i = 0; i < NUM_SRC; i++) begin
        eligible[i] = pend_ff[i] && enable_ff[i];
      end
    end
  end

  // arbitration: a later source replaces the holder only at a strictly higher
  // level, so the lowest index wins inside a level, which is the polling order
  always_comb begin
    winner = '0; // no candidate yet
    for (int i = 0; i < NUM_SRC; i++) begin
      if (eligible[i] && (!winner.valid ||
          src_level(i, prio_hi_ff, prio_lo_ff) > winner.level)) begin
        winner.valid = 1'b1;
        winner.source = 3'(i);
        winner.level = src_level(i, prio_hi_ff, prio_lo_ff);
      end
    end
  end

  // level now in service, shared by the preemption gate and the return path
  assign cur_top = top_active(active_ff);

  // bus answer: fixed one-cycle latency, every request is answered,
  // unmapped addresses included, so a master never hangs on a typo
  always_comb begin
    nxt_ack = bus_req;
  end

  // answer register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= nxt_ack;
    end
  end

  // configuration: enable and both priority registers
  // reserved bits are dropped on write, so they read back as zero
  always_comb begin
    nxt_enable = enable_ff;
    nxt_prio_hi = prio_hi_ff;
    nxt_prio_lo = prio_lo_ff;
    if (wr_stb) begin
      case (adr_i)
        ADDR_ENABLE: begin
          nxt_enable = dat_i[7:0] & ENABLE_USED;
        end
        ADDR_PRIO_HI: begin
          nxt_prio_hi = dat_i[7:0] & SRC_FIELD_MASK;
        end
        ADDR_PRIO_LO: begin
          nxt_prio_lo = dat_i[7:0] & SRC_FIELD_MASK;
        end
        default: begin
          // other addresses leave the configuration alone
        end
      endcase
    end
  end

  // configuration registers; priorities have no fixed reset, zero is used
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      enable_ff <= RST_ENABLE;
      prio_hi_ff <= RST_PRIO;
      prio_lo_ff <= RST_PRIO;
    end else begin
      enable_ff <= nxt_enable;
      prio_hi_ff <= nxt_prio_hi;
      prio_lo_ff <= nxt_prio_lo;
    end
  end

  // events: a request sets its status bit whatever the enables say,
  // so software can poll sources it keeps blocked
  always_comb begin
    nxt_status = status_ff;
    nxt_mask = mask_ff;
    if (wr_stb && adr_i == ADDR_STATUS) begin
      nxt_status = status_ff & ~dat_i[5:0]; // write one to clear
    end
    if (wr_stb && adr_i == ADDR_MASK) begin
      nxt_mask = dat_i[5:0];
    end
    // set wins over a clear in the same cycle, so no event is lost
    nxt_status = nxt_status | src_req_i;
  end

  // status and mask registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status_ff <= RST_STATUS;
      mask_ff <= RST_MASK;
    end else begin
      status_ff <= nxt_status;
      mask_ff <= nxt_mask;
    end
  end

  // pending: sticky until the core takes it; a request in the take cycle
  // keeps the bit set so a back-to-back event is not dropped
  always_comb begin
    nxt_pend = pend_ff | src_req_i;
    if (take) begin
      nxt_pend[vec_ff.source] = src_req_i[vec_ff.source];
    end
  end

  // pending register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pend_ff <= '0;
    end else begin
      pend_ff <= nxt_pend;
    end
  end

  // in service: a return frees the top level before a take marks a new one,
  // so a return and a take in one cycle both land
  always_comb begin
    nxt_active = active_ff;
    if (ret_lvl) begin
      nxt_active[cur_top[1:0]] = 1'b0;
    end
    if (take) begin
      nxt_active[vec_ff.level] = 1'b1;
    end
  end

  // in-service register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      active_ff <= '0;
    end else begin
      active_ff <= nxt_active;
    end
  end

  // vector: the winner, withheld unless it beats the level in service;
  // one cycle behind pending and enables, the price of a registered output
  always_comb begin
    nxt_vec = winner;
    // only a strictly higher level preempts; level three is never beaten
    if (cur_top[2] && winner.level <= cur_top[1:0]) begin
      nxt_vec.valid = 1'b0;
    end
    // a taken vector is dropped at once so the core cannot take it twice
    if (take) begin
      nxt_vec.valid = 1'b0;
    end
  end

  // vector register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      vec_ff <= '0;
    end else begin
      vec_ff <= nxt_vec;
    end
  end

  // read data: registered beside the answer and zero outside a read,
  // so dat_o never shows stale register contents between cycles
  always_comb begin
    nxt_rdat = '0;
    if (rd_stb) begin
      case (adr_i)
        ADDR_ENABLE: begin
          nxt_rdat = {24'h0, enable_ff};
        end
        ADDR_PRIO_HI: begin
          nxt_rdat = {24'h0, prio_hi_ff};
        end
        ADDR_PRIO_LO: begin
          nxt_rdat = {24'h0, prio_lo_ff};
        end
        ADDR_STATUS: begin
          nxt_rdat = {26'h0, status_ff};
        end
        ADDR_MASK: begin
          nxt_rdat = {26'h0, mask_ff};
        end
        ADDR_SERVICE: begin
          nxt_rdat = {22'h0, pend_ff, active_ff};
        end
        default: begin
          nxt_rdat = '0; // unmapped reads return zero
        end
      endcase
    end
  end

  // read data register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdat_ff <= '0;
    end else begin
      rdat_ff <= nxt_rdat;
    end
  end

  // outputs straight from registers, except irq_o below
  assign ack_o = ack_ff;
  assign dat_o = rdat_ff;
  assign vector_o = vec_ff;
  // level interrupt: high while any unmasked event bit is set
  assign irq_o = |(status_ff & mask_ff);
endmodule : four_level_interrupt_control

//--- irq_ctrl_sva.sv
// checker of bus answer, vector gating and preemption of the controller
// assumes one clock, sync reset, register writes in dat_i[7:0] with sel_i[0] set
module irq_ctrl_sva
  import irq_ctrl_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [ADDR_W-1:0] adr_i,
  input wire logic [31:0] dat_i,
  input wire logic ack_o,
  input wire vector_t vector_o,
  input wire logic vector_ack_i,
  input wire logic handler_return_i
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] en_ff, hi_ff, lo_ff, nxt_en, nxt_hi, nxt_lo; // register mirrors
  logic [3:0] act_ff, nxt_act; // levels in service
  logic [1:0] top; // highest level in service
  // mirror follows writes at the answered edge, and the core's take and return
  always_comb begin
    {nxt_en, nxt_hi, nxt_lo, nxt_act} = {en_ff, hi_ff, lo_ff, act_ff};
    if (ack_o && we_i && adr_i == ADDR_ENABLE) nxt_en = dat_i[7:0];
    if (ack_o && we_i && adr_i == ADDR_PRIO_HI) nxt_hi = dat_i[7:0];
    if (ack_o && we_i && adr_i == ADDR_PRIO_LO) nxt_lo = dat_i[7:0];
    if (vector_ack_i && vector_o.valid) nxt_act[vector_o.level] = 1'b1;
    if (handler_return_i) nxt_act[top] = 1'b0;
  end
  // top of the in-service set
  always_comb begin
    top = 2'h0;
    for (int i = 1; i < 4; i++) if (act_ff[i]) top = 2'(i);
  end
  // registers only
  always_ff @(posedge clk_i) {en_ff, hi_ff, lo_ff, act_ff} <= rst_i ? '0 :
      {nxt_en, nxt_hi, nxt_lo, nxt_act};
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_take; cyc_i && stb_i && !ack_o; endsequence
  // skip the edge right after a write or take, where the vector still catches up
  sequence s_live; vector_o.valid && !$past(ack_o) && !$past(vector_ack_i); endsequence
  AST_ACK_LAT: assert property (s_take |=> ack_o)
    else $error("no answer one cycle after request");
  AST_ACK_PULSE: assert property (ack_o |=> !ack_o)
    else $error("answer longer than one cycle");
  AST_RST_QUIET: assert property ($fell(rst_i) |-> !vector_o.valid && !ack_o)
    else $error("outputs active after reset");
  AST_GLOBAL: assert property (s_live |-> en_ff[BIT_GLOBAL_EN])
    else $error("vector offered with global enable clear");
  AST_SRC_EN: assert property (s_live |-> en_ff[vector_o.source])
    else $error("vector offered for a blocked source");
  AST_LEVEL: assert property (s_live |-> vector_o.level ==
      {hi_ff[vector_o.source], lo_ff[vector_o.source]})
    else $error("vector level not from high and low bits");
  AST_PREEMPT: assert property (s_live |-> act_ff == 4'h0 || vector_o.level > top)
    else $error("vector offered at or below level in service");
  AST_TOP_HOLD: assert property (act_ff[3] && !$past(vector_ack_i) |-> !vector_o.valid)
    else $error("level three handler preempted");
endmodule : irq_ctrl_sva
bind four_level_interrupt_control irq_ctrl_sva sva (.*);

//--- core_model.sv
// core stand-in: takes each offered vector at once, returns handlers slowly
// assumes vector_i is registered on clk_i
module core_model
  import irq_ctrl_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic run_i,
  input wire vector_t vector_i,
  output logic ack_o,
  output logic ret_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] dep_ff, tick_ff; // nesting depth, return pacing
  logic go; // take this cycle
  assign go = run_i && vector_i.valid && !ack_o;
  // one take pulse per offer; one return every eight cycles, innermost first
  always_ff @(posedge clk_i) begin
    tick_ff <= rst_i ? 3'h0 : tick_ff + 3'h1;
    ack_o <= !rst_i && go;
    ret_o <= !rst_i && !go && dep_ff != 3'h0 && tick_ff == 3'h0;
    dep_ff <= rst_i ? 3'h0 : dep_ff + 3'(ack_o) - 3'(ret_o);
  end
endmodule : core_model

//--- tb_top.sv
// self-checking bench: wishbone register access, status interrupt, vector choice
// assumes the checker is bound to the controller and the core model answers it
module tb_top;
  import irq_ctrl_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i, rst_i, cyc_i, stb_i, we_i, vector_ack_i, handler_return_i, run, ack_o, irq_o;
  logic [7:0] adr_i, q, e, h, l;
  logic [3:0] sel_i;
  logic [31:0] dat_i, dat_o;
  logic [5:0] src_req_i, p;
  vector_t vector_o;
  int seed, n_errors, total_checks;
  four_level_interrupt_control uut (.*);
  core_model cm (.clk_i, .rst_i, .run_i(run), .vector_i(vector_o), .ack_o(vector_ack_i),
      .ret_o(handler_return_i));
  // expected winner: higher level first, lower index wins a tie
  function automatic vector_t best(logic [5:0] r, logic [7:0] en, hi, lo);
    vector_t v;
    v = '0;
    for (int i = 5; i >= 0; i--) if (en[7] && en[i] && r[i] && (!v.valid ||
        {hi[i], lo[i]} >= v.level)) v = {1'b1, 3'(i), hi[i], lo[i]};
    return v;
  endfunction : best
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk
  // one classic cycle, held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d,
      output logic [7:0] r);
    {cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'b11, w, a, 24'h0, d};
    do @(posedge clk_i); while (ack_o !== 1'b1);
    r = dat_o[7:0];
    {cyc_i, stb_i} <= 2'b00;
    @(posedge clk_i);
  endtask : wb
  task automatic pulse(input logic [5:0] r);
    src_req_i <= r;
    @(posedge clk_i);
    src_req_i <= 6'h00;
    repeat (3) @(posedge clk_i);
  endtask : pulse
  task print_verdict;
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : print_verdict
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  // hang guard, far above the expected few thousand cycles
  initial begin
    repeat (20000) @(posedge clk_i);
    n_errors++;
    print_verdict;
  end
  initial begin
    {cyc_i, stb_i, we_i, adr_i, dat_i, src_req_i, run, rst_i} = '1;
    {cyc_i, stb_i, we_i, adr_i, dat_i, src_req_i, run} = '0;
    sel_i = 4'hF;
    seed = 16628;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb(0, ADDR_ENABLE, 0, q);
    chk(q, RST_ENABLE);
    wb(0, 8'h10, 0, q);
    chk(q, 8'h00);
    // status set by events, level output only while unmasked
    wb(1, ADDR_MASK, 8'h01, q);
    pulse(6'h03);
    chk(8'(irq_o), 8'h01);
    wb(0, ADDR_STATUS, 0, q);
    chk(q, 8'h03);
    wb(1, ADDR_MASK, 8'h02, q);
    wb(1, ADDR_STATUS, 8'h02, q);
    chk(8'(irq_o), 8'h00);
    $display("test status done");
    for (int k = 0; k < 40; k++) begin
      e = 8'($random(seed)) & 8'hBF;
      h = 8'($random(seed)) & 8'h3F;
      l = 8'($random(seed)) & 8'h3F;
      p = 6'($random(seed));
      if (k == 0) {e, h, l, p} = {8'hBF, 8'h3F, 8'h3F, 6'h3F};
      if (k == 1) e = 8'h3F;
      rst_i <= 1'b1;
      @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      wb(1, ADDR_ENABLE, e, q);
      wb(1, ADDR_PRIO_HI, h, q);
      wb(1, ADDR_PRIO_LO, l, q);
      wb(0, ADDR_PRIO_LO, 0, q);
      chk(q, l);
      wb(0, ADDR_PRIO_HI, 0, q);
      chk(q, h);
      wb(0, ADDR_ENABLE, 0, q);
      chk(q, e);
      pulse(p);
      chk(8'(vector_o), 8'(best(p, e, h, l)));
      wb(0, ADDR_SERVICE, 0, q);
      chk(q, {p[3:0], 4'h0});
      run <= 1'b1;
      pulse(~p);
      repeat (100) @(posedge clk_i);
      run <= 1'b0;
      chk(8'(vector_o), 8'h00);
      $display("test %0d done", k);
    end
    print_verdict;
  end
endmodule : tb_top
